// ==== nvm_command_engine.v ====
// Purpose: command sequencer moving bytes between fifo, nvm, config, crc, key
// Assumes: one clock aclk, synchronous active-low aresetn, AXI4-Lite slave
// Notes:   registers are byte wide in bits [7:0]; wstrb[0] gates writes
//
// How it works
// - a programming cycle lasts about 5.8 ms; fifo keeps accepting data
// - reaching the last byte of a 16-byte block starts programming
// - after the last queued byte is programmed, done and tx irq flags rise
// - write command stays active; new data continues at the next address
// - writes to block 0 flag an access violation and are not programmed
// - byte addresses wrap modulo 200h
// - read copies count bytes from nvm into the fifo, then stops
// - reading the key area, blocks 8h-1Fh, flags an access violation
// - config load takes two address bytes, copies 32 bytes, stops
// - config copy from key blocks flags an access violation
// - startup init is a config load from address 10h
// - crc command eats fifo bytes, waits when empty, runs until idle
// - short crc uses polynomial x8+x4+x3+x2+1
// - long crc uses polynomial x16+x12+x5+1
// - fifo drained: crc done and tx irq set, result and fail valid
// - any fault sets the summary error bit and its cause bit
// - key-from-nvm takes two address bytes, loads the key, stops
// - badly formatted key loads anyway and sets the key format flag
// - data gathers in a 16-byte buffer; last byte of the block or fifo empty programs it
// - while programming is unfinished every command is ignored
`include "nvm_engine_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module nvm_command_engine #(
  parameter [31:0] PROG_CYCLES = `PROG_CYCLES
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [47:0] key_value
);
  localparam [2:0] S_IDLE = 3'h0, S_ARG = 3'h1, S_WCOL = 3'h2, S_WPROG = 3'h3;
  localparam [2:0] S_READ = 3'h4, S_CFG = 3'h5, S_KEY = 3'h6, S_CRC = 3'h7;
  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [7:0]  mem [0:511];
  reg [7:0]  cfg [0:31];
  reg [7:0]  fifo [0:15];
  reg [7:0]  wbuf [0:15];
  reg [15:0] wmask;
  reg [4:0]  wblk;
  reg [4:0]  wptr;
  reg [4:0]  rptr;
  reg [2:0]  state;
  reg [7:0]  cmd;
  reg [1:0]  argcnt;
  reg [7:0]  arg0;
  reg [7:0]  arg1;
  reg [8:0]  addr;
  reg [7:0]  cnt;
  reg [31:0] tmr;
  reg        nvm_done_flag;
  reg        checksum_done_flag;
  reg        tx_irq_flag;
  reg        access_violation_flag;
  reg        key_format_flag;
  reg        checksum_fail_flag;
  reg [1:0]  redundancy_config;
  reg [7:0]  checksum_seed_low;
  reg [7:0]  checksum_seed_high;
  reg [15:0] crc;
  reg [47:0] key_sh;
  reg        key_ok;
  reg        aw_hold;
  reg        w_hold;
  reg [7:0]  aw_q;
  reg [31:0] w_q;
  reg        ws_q;
  reg [31:0] rd_mux;
  integer    i;
  // ----------------------------------------
  // fifo view and engine fifo traffic
  // ----------------------------------------
  wire       f_empty = (wptr == rptr);
  wire       f_full  = ((wptr ^ rptr) == 5'h10);
  wire [7:0] f_head  = fifo[rptr[3:0]];
  wire [1:0] argneed = (cmd == `CMD_NVM_READ) ? 2'd3 :
                       (cmd == `CMD_KEY_FIFO || cmd == `CMD_CRC) ? 2'd0 : 2'd2;
  wire       key_src_fifo = (cmd == `CMD_KEY_FIFO);
  wire       key_area = (addr[8:7] != 2'h0);
  wire       eng_pop = !f_empty & ((state == S_ARG && argcnt != argneed) ||
                       state == S_WCOL || state == S_CRC ||
                       (state == S_KEY && key_src_fifo && cnt != `KEY_LAST + 8'h01));
  wire       eng_push = (state == S_READ) && (cnt != 8'h00) && !key_area && !f_full;
  wire       short = redundancy_config[`RC_SHORT];
  wire       hdlc  = redundancy_config[`RC_HDLC];
  wire [15:0] crc_out = hdlc ? ~crc : crc;
  // ----------------------------------------
  // bus write decode
  // ----------------------------------------
  // a host fifo write waits for as long as the engine pushes read bytes
  wire wr_go  = aw_hold & w_hold & ~s_axi_bvalid &
                ~(aw_q == `REG_FIFO_DATA && eng_push);
  wire wr_en  = wr_go & ws_q;
  wire [7:0] wd = w_q[7:0];
  wire do_cmd = wr_en && (aw_q == `REG_CMD);
  wire cmd_ok = !(state == S_WPROG || (state == S_WCOL && !nvm_done_flag));
  wire h_push = wr_en && (aw_q == `REG_FIFO_DATA) && !f_full;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire h_pop  = ar_take && (s_axi_araddr == `REG_FIFO_DATA) && !f_empty && !eng_pop;
  wire irq_clr = wr_en && (aw_q == `REG_MAIN_STAT) && wd[`MS_TX_IRQ];
  wire wr_known = (aw_q[7:2] <= `REG_OUT_HI >> 2) || aw_q[`CFG_WIN_BIT];
  function [15:0] crc_step;
    input [15:0] c;
    input [7:0]  d;
    input        s;
    reg   [15:0] x;
    reg   [7:0]  y;
    integer      k;
    begin
      x = c ^ {d, 8'h00};
      y = c[7:0] ^ d;
      for (k = 0; k < 8; k = k + 1) begin
        x = x[15] ? ({x[14:0], 1'b0} ^ `POLY16) : {x[14:0], 1'b0};
        y = y[7] ? ({y[6:0], 1'b0} ^ `POLY8) : {y[6:0], 1'b0};
      end
      crc_step = s ? {8'h00, y} : x;
    end
  endfunction
  // ----------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_q    <= 8'h00;
      w_q     <= 32'h0000_0000;
      ws_q    <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold       <= 1'b1;
        aw_q          <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold       <= 1'b1;
        w_q          <= s_axi_wdata;
        ws_q         <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= ((s_axi_araddr[7:2] <= `REG_OUT_HI >> 2) ||
                          s_axi_araddr[`CFG_WIN_BIT]) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
  always @* begin
    rd_mux = 32'h0000_0000;
    if (s_axi_araddr[`CFG_WIN_BIT])
      rd_mux[7:0] = cfg[s_axi_araddr[6:2]];
    else
      case (s_axi_araddr)
        `REG_CMD:       rd_mux[7:0] = cmd;
        `REG_MAIN_STAT: begin
          rd_mux[`MS_BUSY]     = (state != S_IDLE);
          rd_mux[`MS_ERR]      = access_violation_flag | key_format_flag |
                                 checksum_fail_flag;
          rd_mux[`MS_NVM_DONE] = nvm_done_flag;
          rd_mux[`MS_CRC_DONE] = checksum_done_flag;
          rd_mux[`MS_TX_IRQ]   = tx_irq_flag;
        end
        `REG_FAULT: begin
          rd_mux[`FC_ACCESS]   = access_violation_flag;
          rd_mux[`FC_KEY]      = key_format_flag;
          rd_mux[`FC_CRC_FAIL] = checksum_fail_flag;
        end
        `REG_FIFO_DATA: rd_mux[7:0] = f_empty ? 8'h00 : f_head;
        `REG_FIFO_LVL:  rd_mux[4:0] = wptr - rptr;
        `REG_REDUND:    rd_mux[1:0] = redundancy_config;
        `REG_SEED_LO:   rd_mux[7:0] = checksum_seed_low;
        `REG_SEED_HI:   rd_mux[7:0] = checksum_seed_high;
        `REG_OUT_LO:    rd_mux[7:0] = crc_out[7:0];
        `REG_OUT_HI:    rd_mux[7:0] = short ? 8'h00 : crc_out[15:8];
        default:        rd_mux = 32'h0000_0000;
      endcase
  end
  // ----------------------------------------
  // fifo pointers and storage
  // ----------------------------------------
  // host push is dropped when full; host pop yields to the engine
  always @(posedge aclk) begin
    if (!aresetn) begin
      wptr <= 5'h00;
      rptr <= 5'h00;
    end else begin
      if (eng_push) begin
        fifo[wptr[3:0]] <= mem[addr];
        wptr <= wptr + 5'h01;
      end else if (h_push) begin
        fifo[wptr[3:0]] <= wd;
        wptr <= wptr + 5'h01;
      end
      if (eng_pop || h_pop)
        rptr <= rptr + 5'h01;
    end
  end
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      state  <= S_CFG;
      addr   <= `CFG_BOOT_ADDR;
      cmd    <= `CMD_IDLE;
      cnt    <= 8'h00;
      argcnt <= 2'h0;
      arg0   <= 8'h00;
      arg1   <= 8'h00;
      tmr    <= 32'h0000_0000;
      wmask  <= 16'h0000;
      wblk   <= 5'h00;
      nvm_done_flag         <= 1'b0;
      checksum_done_flag    <= 1'b0;
      tx_irq_flag           <= 1'b0;
      access_violation_flag <= 1'b0;
      key_format_flag       <= 1'b0;
      checksum_fail_flag    <= 1'b0;
      redundancy_config     <= `REDUND_RESET;
      checksum_seed_low     <= `SEED_RESET;
      checksum_seed_high    <= `SEED_RESET;
      crc    <= 16'h0000;
      key_sh <= 48'h0000_0000_0000;
      key_ok <= 1'b1;
      key_value <= 48'h0000_0000_0000;
    end else begin
      if (irq_clr)
        tx_irq_flag <= 1'b0;
      if (wr_en && aw_q == `REG_REDUND)
        redundancy_config <= wd[1:0];
      if (wr_en && aw_q == `REG_SEED_LO)
        checksum_seed_low <= wd;
      if (wr_en && aw_q == `REG_SEED_HI)
        checksum_seed_high <= wd;
      case (state)
        S_ARG: begin
          if (argcnt == argneed) begin
            // 9-bit address keeps only bit 0 of the high byte
            addr <= {arg1[0], arg0};
            crc  <= short ? {8'h00, checksum_seed_low} :
                            {checksum_seed_high, checksum_seed_low};
            case (cmd)
              `CMD_NVM_WRITE: state <= S_WCOL;
              `CMD_NVM_READ:  state <= S_READ;
              `CMD_CFG_LOAD:  state <= S_CFG;
              `CMD_CRC:       state <= S_CRC;
              default:        state <= S_KEY;
            endcase
          end else if (!f_empty) begin
            if (argcnt == 2'd0)
              arg0 <= f_head;
            if (argcnt == 2'd1)
              arg1 <= f_head;
            // only a read gets this far: its third argument is the count
            if (argcnt == 2'd2)
              cnt <= f_head;
            argcnt <= argcnt + 2'd1;
          end
        end
        S_WCOL: begin
          if (!f_empty) begin
            wbuf[addr[3:0]]   <= f_head;
            wmask[addr[3:0]]  <= 1'b1;
            wblk              <= addr[8:4];
            addr              <= addr + 9'h001;
            nvm_done_flag     <= 1'b0;
            if (addr[3:0] == 4'hF)
              state <= S_WPROG;
          end else if (wmask != 16'h0000) begin
            state <= S_WPROG;
          end else begin
            nvm_done_flag <= 1'b1;
            if (!nvm_done_flag)
              tx_irq_flag <= 1'b1;
          end
          tmr <= 32'h0000_0000;
        end
        S_WPROG: begin
          if (wblk == 5'h00) begin
            access_violation_flag <= 1'b1;
            wmask <= 16'h0000;
            state <= S_WCOL;
          end else if (tmr == PROG_CYCLES - 32'h0000_0001) begin
            for (i = 0; i < 16; i = i + 1)
              if (wmask[i])
                mem[{wblk, i[3:0]}] <= wbuf[i];
            wmask <= 16'h0000;
            state <= S_WCOL;
          end else begin
            tmr <= tmr + 32'h0000_0001;
          end
        end
        S_READ: begin
          if (cnt == 8'h00) begin
            state <= S_IDLE;
          end else if (key_area) begin
            access_violation_flag <= 1'b1;
            state <= S_IDLE;
          end else if (!f_full) begin
            addr <= addr + 9'h001;
            cnt  <= cnt - 8'h01;
          end
        end
        S_CFG: begin
          if (key_area)
            access_violation_flag <= 1'b1;
          else
            cfg[cnt[4:0]] <= mem[addr];
          addr <= addr + 9'h001;
          cnt  <= cnt + 8'h01;
          if (cnt == `CFG_LAST)
            state <= S_IDLE;
        end
        S_KEY: begin
          // each stored byte carries one key nibble and its complement
          if ((!key_src_fifo || !f_empty) && cnt != `KEY_LAST + 8'h01) begin
            key_sh <= {(key_src_fifo ? f_head[3:0] : mem[addr][3:0]), key_sh[47:4]};
            if (key_src_fifo ? (f_head[7:4] != ~f_head[3:0]) :
                               (mem[addr][7:4] != ~mem[addr][3:0]))
              key_ok <= 1'b0;
            addr <= addr + 9'h001;
            cnt  <= cnt + 8'h01;
          end
          if (cnt == `KEY_LAST + 8'h01) begin
            key_value <= key_sh;
            if (!key_ok)
              key_format_flag <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_CRC: begin
          if (!f_empty) begin
            crc <= crc_step(crc, f_head, short);
            checksum_done_flag <= 1'b0;
          end else begin
            checksum_done_flag <= 1'b1;
            if (!checksum_done_flag)
              tx_irq_flag <= 1'b1;
            checksum_fail_flag <= short ? (crc[7:0] != 8'h00) :
                                  (crc != (hdlc ? `HDLC_RESIDUE : 16'h0000));
          end
        end
        default: ;
      endcase
      if (do_cmd && cmd_ok) begin
        cmd    <= wd;
        argcnt <= 2'h0;
        cnt    <= 8'h00;
        key_ok <= 1'b1;
        wmask  <= 16'h0000;
        nvm_done_flag      <= 1'b0;
        checksum_done_flag <= 1'b0;
        access_violation_flag <= 1'b0;
        key_format_flag       <= 1'b0;
        checksum_fail_flag    <= 1'b0;
        if (wd == `CMD_NVM_WRITE || wd == `CMD_NVM_READ || wd == `CMD_CFG_LOAD ||
            wd == `CMD_KEY_NVM || wd == `CMD_CRC || wd == `CMD_KEY_FIFO)
          state <= S_ARG;
        else
          state <= S_IDLE;
      end
    end
  end
endmodule // nvm_command_engine
`default_nettype wire

// ==== nvm_engine_consts.vh ====
// Purpose: constants of the command engine
// Assumes: 32-bit AXI4-Lite data, byte-wide registers in lane 0
// Notes:   definitions only
`ifndef NVM_ENGINE_CONSTS_VH
`define NVM_ENGINE_CONSTS_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define REG_CMD        8'h00
`define REG_MAIN_STAT  8'h04
`define REG_FAULT      8'h08
`define REG_FIFO_DATA  8'h0C
`define REG_FIFO_LVL   8'h10
`define REG_REDUND     8'h14
`define REG_SEED_LO    8'h18
`define REG_SEED_HI    8'h1C
`define REG_OUT_LO     8'h20
`define REG_OUT_HI     8'h24
`define CFG_REG_FIRST  8'h10
`define CFG_WIN_BIT    7
// ----------------------------------------
// command codes
// ----------------------------------------
`define CMD_IDLE       8'h00
`define CMD_NVM_WRITE  8'h01
`define CMD_NVM_READ   8'h03
`define CMD_CFG_LOAD   8'h07
`define CMD_KEY_NVM    8'h0B
`define CMD_CRC        8'h12
`define CMD_KEY_FIFO   8'h19
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define MS_BUSY        0
`define MS_ERR         1
`define MS_NVM_DONE    2
`define MS_CRC_DONE    3
`define MS_TX_IRQ      4
`define FC_ACCESS      0
`define FC_KEY         1
`define FC_CRC_FAIL    2
`define RC_SHORT       0
`define RC_HDLC        1
`define SEED_RESET     8'h00
`define REDUND_RESET   2'h0
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
// ----------------------------------------
// checksum and memory layout
// ----------------------------------------
`define POLY8          8'h1D
`define POLY16         16'h1021
`define HDLC_RESIDUE   16'h1D0F
`define CFG_BOOT_ADDR  9'h010
`define CFG_LAST       8'h1F
`define KEY_LAST       8'h0B
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS  5
`define PROG_TIME_US   5800
`define PROG_CYCLES    ((`PROG_TIME_US * 1000) / `CLK_PERIOD_NS)
`endif

// ==== engine_bus_monitor.sv ====
// Purpose: bus and answer checks at the engine's ports
// Assumes: one clock aclk, synchronous active-low aresetn
// Notes:   attached by bind below the module
`include "nvm_engine_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module engine_bus_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write got no response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read got no data");
  a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_byte_lane: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");
  a_aw_closed: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel open during response");
  a_ar_closed: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read channel open during data");
  a_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp == `RESP_OKAY
    || s_axi_bresp == `RESP_SLVERR) else $error("bad write response code");
  a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
endmodule // engine_bus_monitor
bind nvm_command_engine engine_bus_monitor engine_bus_monitor_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ==== host_bus_model.sv ====
// Purpose: host side of the register bus, one transfer per call
// Assumes: called just after a rising edge
// Notes:   waits without limit; the bench timeout ends a hang
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
  input  wire logic        aclk,
  output var  logic [7:0]  awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var  logic        bready,
  output var  logic [7:0]  araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // leading edge keeps a release and the next raise in separate steps
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule // host_bus_model
`default_nettype wire

// ==== eeprom_crc_key_command_engine_tb_top.sv ====
// Purpose: scenario bench for the command engine
// Assumes: short programming time of 20 cycles
// Notes:   nvm is not reset, so only written bytes are read back
`include "nvm_engine_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module eeprom_crc_key_command_engine_tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [47:0] key_value;
  int          bad_count = 0;
  int          check_count = 0;
  int          cycles = 0;
  always #2.5 aclk = ~aclk;
  nvm_command_engine #(.PROG_CYCLES(32'd20)) nvm_command_engine_i (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .key_value(key_value));
  host_bus_model host_bus_model_i (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test;
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    host_bus_model_i.wr(a, {24'h00_0000, d}, rs);
  endtask
  task automatic get(input logic [7:0] a);
    host_bus_model_i.rd(a, rv, rs);
  endtask
  // leaves main status in rv for the caller to judge
  task automatic wait_flag(input int b, input logic v);
    int n;
    n = 0;
    do begin
      get(`REG_MAIN_STAT);
      n++;
    end while (rv[b] !== v && n < 300);
    if (rv[b] !== v) bad_count++;
  endtask
  function automatic logic [15:0] crc_step(input logic m, input logic [15:0] c,
                                           input logic [7:0] b);
    c = m ? c ^ {b, 8'h00} : {8'h00, c[7:0] ^ b};
    for (int i = 0; i < 8; i++)
      if (m) c = c[15] ? (c << 1) ^ 16'h1021 : c << 1;
      else c = c[7] ? {8'h00, c[6:0], 1'b0} ^ 16'h001d : {8'h00, c[6:0], 1'b0};
    return c;
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    get(`REG_REDUND);
    chk(rv, 32'h0000_0000);
    put(8'h40, 8'h01);
    chk(rs, `RESP_SLVERR);
  endtask
  task automatic t_write;
    put(`REG_FIFO_DATA, 8'h2c);
    put(`REG_FIFO_DATA, 8'h00);
    for (int i = 0; i < 5; i++) put(`REG_FIFO_DATA, 8'(8'hd0 + i));
    put(`REG_CMD, `CMD_NVM_WRITE);
    wait_flag(`MS_NVM_DONE, 1'b1);
    chk(rv[`MS_TX_IRQ], 1'b1);
    put(`REG_MAIN_STAT, 8'h10);
    put(`REG_FIFO_DATA, 8'hd5);
    put(`REG_CMD, `CMD_IDLE);
    wait_flag(`MS_TX_IRQ, 1'b1);
    chk(rv[`MS_BUSY], 1'b1);
    put(`REG_CMD, `CMD_IDLE);
    wait_flag(`MS_BUSY, 1'b0);
    chk(rv[`MS_BUSY], 1'b0);
  endtask
  task automatic t_read;
    put(`REG_FIFO_DATA, 8'h2c);
    put(`REG_FIFO_DATA, 8'h02);
    put(`REG_FIFO_DATA, 8'h06);
    put(`REG_CMD, `CMD_NVM_READ);
    wait_flag(`MS_BUSY, 1'b0);
    for (int i = 0; i < 6; i++) begin
      get(`REG_FIFO_DATA);
      chk(rv, 32'(8'hd0 + i));
    end
  endtask
  task automatic t_cfg;
    put(`REG_FIFO_DATA, 8'h20);
    put(`REG_FIFO_DATA, 8'h00);
    put(`REG_CMD, `CMD_CFG_LOAD);
    wait_flag(`MS_BUSY, 1'b0);
    get(8'hb0);
    chk(rv, 32'h0000_00d0);
    get(8'hc4);
    chk(rv, 32'h0000_00d5);
  endtask
  task automatic t_access;
    logic [7:0] arg [2][3] = '{'{8'h05, 8'h00, 8'haa}, '{8'h00, 8'h01, 8'h01}};
    logic [7:0] op [2] = '{`CMD_NVM_WRITE, `CMD_NVM_READ};
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 3; i++) put(`REG_FIFO_DATA, arg[k][i]);
      put(`REG_CMD, op[k]);
      wait_flag(`MS_ERR, 1'b1);
      chk(rv[`MS_ERR], 1'b1);
      get(`REG_FAULT);
      chk(rv, 32'h0000_0001);
      put(`REG_CMD, `CMD_IDLE);
    end
  endtask
  task automatic t_crc;
    logic [15:0] c, e;
    for (int m = 0; m < 3; m++) begin
      c = m ? 16'hffff : 16'h005a;
      put(`REG_REDUND, 8'(m == 0 ? 1 : 2 * m - 2));
      put(`REG_SEED_LO, c[7:0]);
      put(`REG_SEED_HI, c[15:8]);
      for (int i = 0; i < 3; i++) begin
        put(`REG_FIFO_DATA, 8'(8'h31 + i));
        c = crc_step(m != 0, c, 8'(8'h31 + i));
      end
      put(`REG_MAIN_STAT, 8'h10);
      put(`REG_CMD, `CMD_CRC);
      wait_flag(`MS_CRC_DONE, 1'b1);
      chk(rv[`MS_TX_IRQ], 1'b1);
      e = (m == 2) ? ~c : c;
      get(`REG_OUT_LO);
      chk(rv, e[7:0]);
      get(`REG_OUT_HI);
      chk(rv, e[15:8]);
      get(`REG_FAULT);
      chk(rv[`FC_CRC_FAIL], c != ((m == 2) ? `HDLC_RESIDUE : 16'h0000));
      put(`REG_CMD, `CMD_IDLE);
    end
  endtask
  task automatic t_key;
    logic [47:0] k = 48'h0123_4567_89ab;
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 12; i++)
        put(`REG_FIFO_DATA, {~k[4*i+:4] ^ {3'b000, j == 1 && i == 0}, k[4*i+:4]});
      put(`REG_CMD, `CMD_KEY_FIFO);
      wait_flag(`MS_BUSY, 1'b0);
      get(`REG_FAULT);
      chk(rv[`FC_KEY], j[0]);
      if (j == 0) chk(key_value, k);
    end
  endtask
  // second pass only queues the address for the key fetch
  task automatic t_key_nvm;
    logic [47:0] k = 48'h5a69_c3f0_1e2d;
    for (int j = 0; j < 2; j++) begin
      put(`REG_FIFO_DATA, 8'h40);
      put(`REG_FIFO_DATA, 8'h00);
      if (j == 0) begin
        for (int i = 0; i < 12; i++) put(`REG_FIFO_DATA, {~k[4*i+:4], k[4*i+:4]});
        put(`REG_CMD, `CMD_NVM_WRITE);
        wait_flag(`MS_NVM_DONE, 1'b1);
        put(`REG_CMD, `CMD_IDLE);
      end
    end
    put(`REG_CMD, `CMD_KEY_NVM);
    wait_flag(`MS_BUSY, 1'b0);
    chk(key_value, k);
  endtask
  // ----------------------------------------
  // sequence and timeout
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    wait_flag(`MS_BUSY, 1'b0);
    chk(rv[`MS_BUSY], 1'b0);
    t_regs;
    t_write;
    t_read;
    t_cfg;
    t_access;
    t_crc;
    t_key;
    t_key_nvm;
    end_of_test;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      end_of_test;
    end
  end
endmodule // eeprom_crc_key_command_engine_tb_top
`default_nettype wire
